// ### common/csm_pkg.sv
/*
  constants, register map and carrier types for the card status and
  interrupt mask block.
  assumes a 32-bit ahb-lite slave port with word-aligned registers.
*/
package csm_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets, low address bits only)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_LIVE = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_PRIMARY = 8'h0c;
  localparam logic [7:0] OFF_CLK_CTRL = 8'h10;

  // ----------------------------------------------------------------
  // primary flag / mask layout
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_W = 14;
  localparam logic [13:0] MASK_IMPL = 14'h3eff;
  localparam logic [13:0] MASK_RESET = 14'h0000;
  localparam logic [13:0] IRQ_STAT_RESET = 14'h0000;

  // ----------------------------------------------------------------
  // card clock control word
  // ----------------------------------------------------------------
  localparam int unsigned CLK_DIV_W = 8;
  localparam int unsigned CLK_DIV_LSB = 0;
  localparam int unsigned CLK_EN_BIT = 8;
  localparam logic [7:0] CLK_DIV_RESET = 8'h04;
  localparam logic CLK_EN_RESET = 1'b0;

  // ----------------------------------------------------------------
  // ahb-lite encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cmd_completion;
    logic transfer_done;
    logic data3_edge;
    logic rx_ready;
    logic tx_ready;
    logic rsvd8;
    logic resp_crc_err;
    logic rd_crc_err;
    logic wr_crc_err;
    logic resp_timeout;
    logic rd_timeout;
    logic cmd_resp_done;
    logic busy_done;
    logic data_done;
  } csm_flags_t;

  typedef struct packed {
    logic [24:0] rsvd;
    logic fifo_full;
    logic fifo_empty;
    logic data3_level;
    logic rx_shift_full;
    logic tx_shift_empty;
    logic card_clock_stopped;
    logic card_busy;
  } csm_live_t;

  typedef struct packed {
    logic fifo_full;
    logic fifo_empty;
    logic rx_shift_full;
    logic tx_shift_empty;
    logic card_busy;
  } csm_card_in_t;

endpackage

// ### src/csm_top.sv
/*
  card controller live status, interrupt mask, sticky interrupt status
  and card clock gating, behind an ahb-lite slave port.
  assumes all flag inputs are synchronous to clk and a single ahb master.
*/
`timescale 1ns/100ps
// Function
// - live status bit 4 shows the sampled data line 3 pin level
// - live status bit 3 is one while the receive shift register is full
// - live status bit 2 is one while the transmit shift register is empty
// - card clock held low, bit 1 set, on disable, rx full or tx empty
// - live status bit 0 is one while the card signals busy
// - mask bits enable on one, disable on zero, read/write, reset to zero
// - interrupt only from a latched rising primary flag while its mask bit is set
// - mask bit 13 gates the command completion interrupt
// - mask bit 12 gates the transfer done interrupt
// - mask bit 11 gates the data line 3 edge interrupt
// - mask bit 10 gates the receive data ready interrupt
// - mask bit 9 gates the transmit data ready interrupt
// - mask bit 7 gates the response crc error interrupt
// - mask bit 6 gates the read-data crc error interrupt
// - mask bit 5 gates the write-data crc error interrupt, one enables
// - mask bits 4..0 gate timeouts, response done, busy done, data done
// - live status word is read-only and raises no interrupt
module csm_top #(
  parameter int unsigned DIV_W = csm_pkg::CLK_DIV_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire csm_pkg::csm_flags_t primary_status_word,
  input wire csm_pkg::csm_card_in_t card_in,
  input wire logic card_data3_pin,
  output logic irq,
  output logic card_clock_pin,
  output logic card_clock_stopped_flag
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr[7:2] == off[7:2]);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [13:0] mask_reg;
  logic [13:0] irq_stat_reg;
  logic [13:0] irq_stat_next;
  logic [13:0] flags_prev_reg;
  logic primed_reg;
  logic [13:0] rise;
  logic [13:0] w1c;
  csm_pkg::csm_live_t live_reg;
  csm_pkg::csm_live_t live_next;
  logic clk_en_reg;
  logic [DIV_W-1:0] clk_div_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic div_tick;
  logic clk_stop;
  logic card_clk_reg;
  logic irq_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic addr_phase;
  logic [31:0] rd_mux;
  logic [13:0] flags_vec;

  assign flags_vec = primary_status_word;

  // ----------------------------------------------------------------
  // ahb-lite address phase capture
  // ----------------------------------------------------------------
  // zero wait states: reads are muxed in the address phase, writes land
  // in the data phase; hsize is not checked, every access is a word
  assign addr_phase = hsel && hready && htrans[1];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hreadyout_reg <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_hit(haddr[7:0], csm_pkg::OFF_LIVE)) begin
      rd_mux = live_reg;
    end else if (reg_hit(haddr[7:0], csm_pkg::OFF_MASK)) begin
      rd_mux[13:0] = mask_reg;
    end else if (reg_hit(haddr[7:0], csm_pkg::OFF_IRQ_STAT)) begin
      rd_mux[13:0] = irq_stat_reg;
    end else if (reg_hit(haddr[7:0], csm_pkg::OFF_PRIMARY)) begin
      rd_mux[13:0] = flags_vec & csm_pkg::MASK_IMPL;
    end else if (reg_hit(haddr[7:0], csm_pkg::OFF_CLK_CTRL)) begin
      rd_mux[csm_pkg::CLK_DIV_LSB +: DIV_W] = clk_div_reg;
      rd_mux[csm_pkg::CLK_EN_BIT] = clk_en_reg;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata_reg <= rd_mux;
    end else if (hready) begin
      hrdata_reg <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // interrupt mask register
  // ----------------------------------------------------------------
  // reserved bits 15..14 and 8 are never stored and read zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_reg <= csm_pkg::MASK_RESET;
    end else if (wr_pend_reg && reg_hit(wr_addr_reg, csm_pkg::OFF_MASK)) begin
      mask_reg <= hwdata[13:0] & csm_pkg::MASK_IMPL;
    end
  end

  // ----------------------------------------------------------------
  // rising edge detect on the primary flags
  // ----------------------------------------------------------------
  // primed blocks a false edge from flags already high at reset release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_prev_reg <= 14'h0000;
      primed_reg <= 1'b0;
    end else begin
      flags_prev_reg <= flags_vec;
      primed_reg <= 1'b1;
    end
  end

  // a flag held high gives one edge only
  assign rise = primed_reg ? (flags_vec & ~flags_prev_reg & csm_pkg::MASK_IMPL)
                           : 14'h0000;

  assign w1c = (wr_pend_reg && reg_hit(wr_addr_reg, csm_pkg::OFF_IRQ_STAT))
               ? hwdata[13:0] : 14'h0000;

  // ----------------------------------------------------------------
  // sticky interrupt status, set wins over write-one-to-clear
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < csm_pkg::FLAG_W; gi++) begin : g_sticky
      always_comb begin
        irq_stat_next[gi] = rise[gi] || (irq_stat_reg[gi] && !w1c[gi]);
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_reg <= csm_pkg::IRQ_STAT_RESET;
    end else begin
      irq_stat_reg <= irq_stat_next & csm_pkg::MASK_IMPL;
    end
  end

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  // per-bit gating: 13 cmd completion, 12 transfer done, 11 dat3 edge,
  // 10 rx ready, 9 tx ready, 7..5 crc errors, 4..0 timeouts and dones
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // card clock control word
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_en_reg <= csm_pkg::CLK_EN_RESET;
      clk_div_reg <= DIV_W'(csm_pkg::CLK_DIV_RESET);
    end else if (wr_pend_reg && reg_hit(wr_addr_reg, csm_pkg::OFF_CLK_CTRL)) begin
      clk_en_reg <= hwdata[csm_pkg::CLK_EN_BIT];
      clk_div_reg <= hwdata[csm_pkg::CLK_DIV_LSB +: DIV_W];
    end
  end

  // ----------------------------------------------------------------
  // card clock divider and gating
  // ----------------------------------------------------------------
  // card clock = clk / (2 * (div + 1)); the pin is parked low, never mid-high
  assign clk_stop = !clk_en_reg || card_in.rx_shift_full || card_in.tx_shift_empty;
  assign div_tick = (div_cnt_reg == '0);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_reg <= '0;
    end else if (clk_stop || div_tick) begin
      div_cnt_reg <= clk_div_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      card_clk_reg <= 1'b0;
    end else if (clk_stop) begin
      card_clk_reg <= 1'b0;
    end else if (div_tick) begin
      card_clk_reg <= !card_clk_reg;
    end
  end

  // ----------------------------------------------------------------
  // live status word
  // ----------------------------------------------------------------
  // one register stage, so the word lags its inputs by one cycle
  always_comb begin
    live_next = '0;
    live_next.fifo_full = card_in.fifo_full;
    live_next.fifo_empty = card_in.fifo_empty;
    live_next.data3_level = card_data3_pin;
    live_next.rx_shift_full = card_in.rx_shift_full;
    live_next.tx_shift_empty = card_in.tx_shift_empty;
    live_next.card_clock_stopped = clk_stop;
    live_next.card_busy = card_in.card_busy;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      live_reg <= '0;
    end else begin
      live_reg <= live_next;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      card_clock_stopped_flag <= 1'b1;
    end else begin
      card_clock_stopped_flag <= clk_stop;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = csm_pkg::HRESP_OKAY;
  assign irq = irq_reg;
  assign card_clock_pin = card_clk_reg;

endmodule

// ### dv/csm_card_model.sv
/* card side model: busy and data line 3 levels, card clock rise count.
   assumes the bench steers busy_cmd and d3_cmd after clock edges. */
`timescale 1ns/100ps
module csm_card_model (
  input wire logic rst,
  input wire logic card_clock_pin,
  input wire logic busy_cmd,
  input wire logic d3_cmd,
  output logic card_busy,
  output logic card_data3_pin,
  output logic [15:0] clk_edges
);
  // ----------
  // card lines
  // ----------
  assign card_busy = busy_cmd;
  // line 3 follows d3_cmd directly, and the bench idles it high
  assign card_data3_pin = d3_cmd;
  always @(posedge card_clock_pin or posedge rst) begin
    if (rst)
      clk_edges <= 16'h0000;
    else
      clk_edges <= clk_edges + 16'h0001;
  end
endmodule

// ### dv/csm_chk.sv
/* concurrent checks on the ports of csm_top.
   assumes attachment through the bind at the foot of this file. */
`timescale 1ns/100ps
module csm_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire csm_pkg::csm_flags_t primary_status_word,
  input wire csm_pkg::csm_card_in_t card_in,
  input wire logic card_data3_pin,
  input wire logic irq,
  input wire logic card_clock_pin,
  input wire logic card_clock_stopped_flag
);
  // ----------
  // properties
  // ----------
  logic [13:0] prev_reg;
  logic [3:0] cause_reg;
  logic wr_any_reg;
  wire logic take = hsel && hready && htrans[1];
  wire logic wr = take && hwrite;
  wire logic [13:0] pf = primary_status_word;
  // lenient at release: a flag high there counts as a cause
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_reg <= 14'h0000;
      cause_reg <= 4'h0;
      wr_any_reg <= 1'b0;
    end else begin
      prev_reg <= pf;
      cause_reg <= {cause_reg[2:0], (|(pf & ~prev_reg)) || wr};
      wr_any_reg <= wr_any_reg || wr;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_live_rd;
    take && !hwrite && haddr[7:0] == csm_pkg::OFF_LIVE
      && $stable(card_in) && $stable(card_data3_pin);
  endsequence
  sequence s_w1c;
    wr && haddr[7:0] == csm_pkg::OFF_IRQ_STAT ##1 hwdata[13:0] == 14'h3fff && $stable(pf);
  endsequence
  property p_live;
    s_live_rd |=> hrdata[6:0] == {$past({card_in[4:3], card_data3_pin, card_in[2:1]}),
      $past(card_clock_stopped_flag), $past(card_in[0])};
  endproperty
  a_live: assert property (p_live) else $error("live status bits wrong");
  property p_live_hi;
    s_live_rd |=> hrdata[31:7] == 25'h0000000;
  endproperty
  a_live_hi: assert property (p_live_hi) else $error("live upper bits set");
  property p_stop;
    card_in.rx_shift_full || card_in.tx_shift_empty |=> card_clock_stopped_flag;
  endproperty
  a_stop: assert property (p_stop) else $error("clock stop flag missing");
  property p_pin_low;
    card_clock_stopped_flag |-> !card_clock_pin;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("card clock high while stopped");
  property p_cause;
    $rose(irq) |-> |cause_reg;
  endproperty
  a_cause: assert property (p_cause) else $error("irq rose without cause");
  property p_mask_rst;
    !wr_any_reg |-> !irq;
  endproperty
  a_mask_rst: assert property (p_mask_rst) else $error("irq before any mask write");
  property p_w1c;
    s_w1c |=> ##1 !irq;
  endproperty
  a_w1c: assert property (p_w1c) else $error("irq stayed after clear");
  property p_okay;
    hresp == csm_pkg::HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
endmodule

bind csm_top csm_chk u_csm_chk (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .hresp, .primary_status_word, .card_in, .card_data3_pin, .irq,
  .card_clock_pin, .card_clock_stopped_flag);

// ### dv/tb_top.sv
/* self-checking bench for csm_top with the card side model.
   assumes the checker is bound in from its own file. */
`timescale 1ns/100ps
module tb_top;
  // -----
  // bench
  // -----
  logic clk = 1'b0;
  logic sys_rst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = csm_pkg::HTRANS_IDLE;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [13:0] pf = 14'h0;
  logic [4:0] ci = 5'h0;
  logic busy_cmd = 1'b0;
  logic d3_cmd = 1'b1;
  logic irq;
  logic ck_pin;
  logic stop;
  logic busy;
  logic d3;
  logic [15:0] edges;
  logic [15:0] e0;
  logic [31:0] rd;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  csm_pkg::csm_card_in_t card_in;
  assign card_in = {ci[4:1], busy};
  initial forever #5 clk = ~clk;
  csm_top u_csm_top (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .primary_status_word(pf), .card_in,
    .card_data3_pin(d3), .irq, .card_clock_pin(ck_pin), .card_clock_stopped_flag(stop));
  csm_card_model u_csm_card_model (.rst(sys_rst), .card_clock_pin(ck_pin), .busy_cmd,
    .d3_cmd, .card_busy(busy), .card_data3_pin(d3), .clk_edges(edges));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // single word transfer; waits on hready, no fixed latency assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= csm_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= csm_pkg::HTRANS_IDLE;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    logic [5:0] v;
    logic [13:0] b1;
    logic [13:0] e;
    // a real edge at time zero, so the card model's counter resets too
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    tick(2);
    xfer(1'b0, csm_pkg::OFF_MASK, 32'h0);
    chk("mask reset", rd, 32'h0);
    xfer(1'b1, 8'h20, 32'hffffffff);
    xfer(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    // v: fifo full, fifo empty, line 3, rx full, tx empty, busy
    for (int i = 0; i < 7; i++) begin
      v = 6'h01 << i;
      ci <= {v[5:4], v[2:1], 1'b0};
      busy_cmd <= v[0];
      d3_cmd <= v[3];
      tick(3);
      xfer(1'b1, csm_pkg::OFF_LIVE, 32'hffffffff);
      xfer(1'b0, csm_pkg::OFF_LIVE, 32'h0);
      chk("live", rd, {25'h0, v[5:1], 1'b1, v[0]});
    end
    d3_cmd <= 1'b1;
    xfer(1'b0, csm_pkg::OFF_IRQ_STAT, 32'h0);
    chk("no live irq", rd, 32'h0);
    $display("test live done");
    xfer(1'b1, csm_pkg::OFF_MASK, 32'hffffffff);
    xfer(1'b0, csm_pkg::OFF_MASK, 32'h0);
    chk("mask ones", rd, {18'h0, csm_pkg::MASK_IMPL});
    for (int b = 0; b < 14; b++) begin
      b1 = 14'h0001 << b;
      e = (b == 8) ? 14'h0 : b1;
      xfer(1'b1, csm_pkg::OFF_MASK, {18'h0, ~b1});
      pf <= b1;
      tick(4);
      chk("irq masked", irq, 32'h0);
      xfer(1'b0, csm_pkg::OFF_IRQ_STAT, 32'h0);
      chk("irq status", rd, {18'h0, e});
      xfer(1'b1, csm_pkg::OFF_MASK, {18'h0, b1});
      tick(3);
      chk("irq unmasked", irq, e != 14'h0);
      xfer(1'b1, csm_pkg::OFF_IRQ_STAT, 32'hffffffff);
      tick(4);
      chk("irq held flag", irq, 32'h0);
      pf <= 14'h0;
      tick(2);
    end
    $display("test irq done");
    ci <= 5'h00;
    xfer(1'b1, csm_pkg::OFF_CLK_CTRL, 32'h00000101);
    tick(4);
    e0 = edges;
    tick(40);
    chk("clock runs", (edges - e0) inside {[9:11]}, 32'h1);
    xfer(1'b0, csm_pkg::OFF_LIVE, 32'h0);
    chk("clock live bit", rd[1], 32'h0);
    for (int k = 0; k < 3; k++) begin
      ci <= (k == 0) ? 5'h04 : (k == 1) ? 5'h02 : 5'h00;
      if (k == 2)
        xfer(1'b1, csm_pkg::OFF_CLK_CTRL, 32'h00000001);
      tick(3);
      e0 = edges;
      tick(20);
      xfer(1'b0, csm_pkg::OFF_LIVE, 32'h0);
      chk("clock stopped", {edges == e0, rd[1]}, 32'h3);
    end
    $display("test clock done");
    // mid-run reset: the mask holds a set bit here and must come back zero
    sys_rst <= 1'b1;
    tick(4);
    sys_rst <= 1'b0;
    tick(2);
    xfer(1'b0, csm_pkg::OFF_MASK, 32'h0);
    chk("mask after reset", rd, 32'h0);
    $display("test reset done");
    give_verdict();
  end
endmodule
